/* design/flash_rel_consts.svh */
`ifndef FLASH_REL_CONSTS_SVH
`define FLASH_REL_CONSTS_SVH
// register indices; byte address is four times the index
`define IDX_SUPPORT 8'ha6
`define IDX_CONFIG 8'ha7
`define IDX_ERASED 8'hb5
`define IDX_SECTOR_COUNT 8'hde
`define IDX_ERASE_MULT 8'hf0
`define IDX_STATUS 8'hf1
`define IDX_PURGE_MULT 8'hf2
// reset and fixed values
`define SUPPORT_VALUE 8'h05
`define CONFIG_RESET 5'h1f
`define SECTOR_COUNT_VALUE 8'h01
`define PURGE_MULT_VALUE 8'h11
`define ERASE_MULT_RESET 8'h01
// field positions, config width, last reliable partition and reliable unit length
`define SUP_HOST_CTRL 0
`define SUP_ENHANCED 2
`define CFG_BITS 5
`define LAST_REL_PART 3'h4
`define RELIABLE_UNIT 12'h200
// timing
`define CLK_NS 10
`define MS_NS 1000000
`define STEP_MS 300
`endif

/* design/flash_rel_pkg.sv */
package flash_rel_pkg;
  typedef struct packed {
    logic mark;
    logic purge;
    logic wr;
    logic rel;
    logic [2:0] part;
    logic [11:0] blocklen;
  } link_req_s;
  typedef enum logic {PURGE_IDLE, PURGE_BUSY} purge_state_e;
endpackage

/* design/flash_write_reliability_trim.sv */
// Local design decision: the APB register port.
`timescale 1ns/1ns
`include "flash_rel_consts.svh"
// Notes on behaviour
// RL1: config byte has enables for user area (bit 0) and partitions 1-4 (bits 1-4), 7:5 reserved.
// RL2: the enables are read-only when host control reads 0 and host-writable when it reads 1.
// RL3: the host programs the reliability mode before it completes partitioning.
// RL4: reliability settings only affect user area and general purpose partitions.
// RL5: enhanced flag reads 1 for the enhanced definition, making each sector atomic.
// RL6: reliable writes ignore the programmed block length, use 512-byte units, any length.
// RL7: reliable write sector count reads 0x01 at byte 222.
// RL8: support byte 166 reads 0x05 and config byte 167 resets to 0x1F.
// RL9: secure trim marks blocks in a first step and purges them in a second step.
// RL10: the purge finishes within 300 ms times erase multiplier times purge multiplier (0x11).
// RL11: from marking until the purge completes, byte 181 shows the marked area.
// RL12: a purge request with nothing marked performs no purge.
// RL13: writes to the reserved config bits are dropped and they read as zero.
module flash_write_reliability_trim #(
  parameter logic [7:0] SUPPORT = `SUPPORT_VALUE,
  parameter int MS_CYCLES = `MS_NS / `CLK_NS
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // card link, asynchronous to pclk
  input wire logic card_clk,
  input wire flash_rel_pkg::link_req_s card_req,
  // flash back end
  input wire logic purge_done,
  output logic wr_start,
  output logic wr_reliable,
  output logic wr_protected,
  output logic wr_atomic,
  output logic [11:0] wr_unit_len,
  output logic purge_start,
  output logic purge_busy,
  output logic purge_skipped,
  output logic purge_timeout
);
  if (MS_CYCLES < 1) begin : g_chk
    $error("MS_CYCLES must be at least 1");
  end

  // link synchronisers; stage one feeds stage two only
  logic clk_s1, clk_s2, clk_s3;
  flash_rel_pkg::link_req_s req_s1, req_s2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
      req_s1 <= '0;
      req_s2 <= '0;
    end else begin
      clk_s1 <= card_clk;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      req_s1 <= card_req;
      req_s2 <= req_s1;
    end
  end
  // host changes requests away from the rising card clock edge, so they are settled here
  wire card_rise = clk_s2 & ~clk_s3;
  wire take_mark = card_rise & req_s2.mark;
  wire take_purge = card_rise & req_s2.purge;
  wire take_wr = card_rise & req_s2.wr;

  // registers
  logic [4:0] rel_config;
  logic [7:0] erase_mult;
  logic marked;
  flash_rel_pkg::purge_state_e pstate;

  wire host_ctrl = SUPPORT[`SUP_HOST_CTRL];
  wire enhanced = SUPPORT[`SUP_ENHANCED];
  wire [9:0] word = paddr[11:2];
  wire sel_support = word == {2'b00, `IDX_SUPPORT};
  wire sel_config = word == {2'b00, `IDX_CONFIG};
  wire sel_erased = word == {2'b00, `IDX_ERASED};
  wire sel_sector = word == {2'b00, `IDX_SECTOR_COUNT};
  wire sel_emult = word == {2'b00, `IDX_ERASE_MULT};
  wire sel_status = word == {2'b00, `IDX_STATUS};
  wire sel_pmult = word == {2'b00, `IDX_PURGE_MULT};
  wire mapped = sel_support | sel_config | sel_erased | sel_sector | sel_emult
    | sel_status | sel_pmult;
  wire setup = psel & ~penable;
  wire wr_acc = psel & penable & pwrite;
  wire cfg_we = wr_acc & sel_config & host_ctrl; // [RL2]
  wire emult_we = wr_acc & sel_emult;
  wire [7:0] status_byte = {4'h0, purge_timeout, purge_skipped, marked, purge_busy};
  wire [7:0] rd_byte =
    sel_support ? SUPPORT : // [RL8]
    sel_config ? {3'b000, rel_config} : // [RL1] [RL13]
    sel_erased ? {7'h00, marked} : // [RL11]
    sel_sector ? `SECTOR_COUNT_VALUE : // [RL7]
    sel_emult ? erase_mult :
    sel_status ? status_byte :
    sel_pmult ? `PURGE_MULT_VALUE : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        prdata <= {24'h00_0000, rd_byte};
        pslverr <= ~mapped;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel_config <= `CONFIG_RESET; // [RL8]
      erase_mult <= `ERASE_MULT_RESET;
    end else begin
      // reserved upper bits are never stored
      if (cfg_we) rel_config <= pwdata[`CFG_BITS-1:0]; // [RL2] [RL13]
      if (emult_we) erase_mult <= pwdata[7:0];
    end
  end

  // write path
  wire part_ok = req_s2.part <= `LAST_REL_PART;
  wire [7:0] cfg_wide = {3'b000, rel_config};
  wire next_prot = part_ok & cfg_wide[req_s2.part]; // [RL4]
  wire [11:0] next_len = req_s2.rel ? `RELIABLE_UNIT : req_s2.blocklen; // [RL6]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_start <= 1'b0;
      wr_reliable <= 1'b0;
      wr_protected <= 1'b0;
      wr_atomic <= 1'b0;
      wr_unit_len <= 12'h000;
    end else begin
      wr_start <= take_wr;
      if (take_wr) begin
        wr_reliable <= req_s2.rel;
        wr_protected <= next_prot; // [RL4]
        wr_atomic <= req_s2.rel & enhanced; // [RL5]
        wr_unit_len <= next_len; // [RL6]
      end
    end
  end

  // secure trim
  logic [31:0] ms_div;
  logic [31:0] ms_count;
  wire ms_tick = ms_div == 32'(MS_CYCLES - 1);
  wire [31:0] limit = 32'(`STEP_MS) * {24'h00_0000, erase_mult}
    * {24'h00_0000, `PURGE_MULT_VALUE}; // [RL10]
  wire busy = pstate == flash_rel_pkg::PURGE_BUSY;
  wire expired = busy & (ms_count >= limit);
  wire finish = busy & purge_done;
  wire go = take_purge & ~busy & marked; // [RL9] [RL12]
  // a mark arriving with completion survives the clear
  wire next_marked = take_mark | (marked & ~finish); // [RL9] [RL11]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pstate <= flash_rel_pkg::PURGE_IDLE;
      marked <= 1'b0;
      ms_div <= 32'h0000_0000;
      ms_count <= 32'h0000_0000;
      purge_start <= 1'b0;
      purge_busy <= 1'b0;
      purge_skipped <= 1'b0;
      purge_timeout <= 1'b0;
    end else begin
      marked <= next_marked;
      purge_start <= go;
      purge_skipped <= take_purge & ~busy & ~marked; // [RL12]
      if (go) purge_timeout <= 1'b0;
      else if (expired & ~purge_done) purge_timeout <= 1'b1; // [RL10]
      unique case (pstate)
        flash_rel_pkg::PURGE_IDLE: begin
          ms_div <= 32'h0000_0000;
          ms_count <= 32'h0000_0000;
          if (go) pstate <= flash_rel_pkg::PURGE_BUSY;
        end
        flash_rel_pkg::PURGE_BUSY: begin
          ms_div <= ms_tick ? 32'h0000_0000 : ms_div + 32'h0000_0001;
          if (ms_tick) ms_count <= ms_count + 32'h0000_0001;
          // on timeout the marks stay so the host may retry
          if (finish | expired) pstate <= flash_rel_pkg::PURGE_IDLE;
        end
      endcase
      purge_busy <= (pstate == flash_rel_pkg::PURGE_IDLE) ? go : ~(finish | expired);
    end
  end

  // checks
  property p_cfg_ro;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && sel_config && !host_ctrl) |=> $stable(rel_config);
  endproperty
  a_cfg_ro: assert property (p_cfg_ro) else $error("config changed while read-only"); // [RL2]

  property p_rsv;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite && sel_config) |-> prdata[7:5] == 3'b000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved config bits not zero"); // [RL13]

  property p_boot;
    @(posedge pclk) disable iff (!presetn)
      take_wr && !part_ok |=> wr_start && !wr_protected;
  endproperty
  a_boot: assert property (p_boot) else $error("boot or rpmb write got reliability"); // [RL4]

  property p_atomic;
    @(posedge pclk) disable iff (!presetn)
      take_wr |=> wr_atomic == ($past(req_s2.rel) && enhanced);
  endproperty
  a_atomic: assert property (p_atomic) else $error("atomic flag wrong"); // [RL5]

  property p_unit;
    @(posedge pclk) disable iff (!presetn)
      take_wr && req_s2.rel |=> wr_unit_len == `RELIABLE_UNIT;
  endproperty
  a_unit: assert property (p_unit) else $error("reliable unit not 512"); // [RL6]

  property p_sector;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite && sel_sector) |-> prdata == 32'h0000_0001;
  endproperty
  a_sector: assert property (p_sector) else $error("sector count not 1"); // [RL7]

  property p_support;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite && sel_support) |-> prdata[7:0] == SUPPORT;
  endproperty
  a_support: assert property (p_support) else $error("support byte wrong"); // [RL8]

  property p_erased;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite && sel_erased && $past(marked)) |-> prdata[0];
  endproperty
  a_erased: assert property (p_erased) else $error("marked area not shown"); // [RL11]

  property p_skip;
    @(posedge pclk) disable iff (!presetn)
      take_purge && !marked && !busy |=> !purge_start && !purge_busy && purge_skipped;
  endproperty
  a_skip: assert property (p_skip) else $error("purge ran with nothing marked"); // [RL12]

  property p_start;
    @(posedge pclk) disable iff (!presetn)
      go |=> purge_start && purge_busy ##1 !purge_start;
  endproperty
  a_start: assert property (p_start) else $error("purge start wrong"); // [RL9]

  property p_limit;
    @(posedge pclk) disable iff (!presetn)
      expired && !purge_done |=> purge_timeout && !purge_busy;
  endproperty
  a_limit: assert property (p_limit) else $error("purge overran its timeout"); // [RL10]

  // the writable side of the config byte: the stored value is the written one
  property p_cfg_rw;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && sel_config && host_ctrl) |=> rel_config == $past(pwdata[`CFG_BITS-1:0]);
  endproperty
  a_cfg_rw: assert property (p_cfg_rw) else $error("config write not stored"); // [RL2]

  property p_user_prot;
    @(posedge pclk) disable iff (!presetn)
      take_wr && req_s2.part == 3'h0 |=> wr_protected == $past(rel_config[0]);
  endproperty
  a_user_prot: assert property (p_user_prot) else $error("user area enable ignored"); // [RL1] [RL4]

  property p_part_prot;
    @(posedge pclk) disable iff (!presetn)
      take_wr && req_s2.part == `LAST_REL_PART |=> wr_protected == $past(rel_config[`LAST_REL_PART]);
  endproperty
  a_part_prot: assert property (p_part_prot) else $error("partition enable ignored"); // [RL1] [RL4]

  property p_plain_len;
    @(posedge pclk) disable iff (!presetn)
      take_wr && !req_s2.rel |=> wr_unit_len == $past(req_s2.blocklen);
  endproperty
  a_plain_len: assert property (p_plain_len) else $error("plain write length lost"); // [RL6]

  // legacy definition: no per-sector atomicity even for reliable writes
  property p_legacy;
    @(posedge pclk) disable iff (!presetn)
      take_wr && !enhanced |=> !wr_atomic;
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy write made atomic"); // [RL5]

  property p_erased_clr;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite && sel_erased && !$past(marked)) |-> !prdata[0];
  endproperty
  a_erased_clr: assert property (p_erased_clr) else $error("unmarked area shown"); // [RL11]

  property p_mark_hold;
    @(posedge pclk) disable iff (!presetn)
      marked && !finish |=> marked;
  endproperty
  a_mark_hold: assert property (p_mark_hold) else $error("marks lost before purge"); // [RL11]

  property p_no_purge;
    @(posedge pclk) disable iff (!presetn)
      !marked |=> !purge_start;
  endproperty
  a_no_purge: assert property (p_no_purge) else $error("purge with no marks"); // [RL12]

  property p_busy_end;
    @(posedge pclk) disable iff (!presetn)
      busy && purge_done |=> !purge_busy;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy after purge done"); // [RL9]

  // a fresh mark in the completion cycle is the only thing that may keep marked set
  property p_mark_clear;
    @(posedge pclk) disable iff (!presetn)
      finish && !take_mark |=> !marked;
  endproperty
  a_mark_clear: assert property (p_mark_clear) else $error("marks kept after purge"); // [RL9]

  property p_busy_ignore;
    @(posedge pclk) disable iff (!presetn)
      busy && take_purge |=> !purge_start && !purge_skipped;
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("purge restarted while busy"); // [RL9]

  property p_pmult;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite && sel_pmult) |-> prdata == {24'h00_0000, `PURGE_MULT_VALUE};
  endproperty
  a_pmult: assert property (p_pmult) else $error("purge multiplier wrong"); // [RL10]

  property p_timeout_clr;
    @(posedge pclk) disable iff (!presetn)
      go |=> !purge_timeout;
  endproperty
  a_timeout_clr: assert property (p_timeout_clr) else $error("stale timeout flag"); // [RL10]
endmodule

/* sim/card_host_model.sv */
`timescale 1ns/1ns
module card_host_model (
  // card link
  output logic card_clk,
  output flash_rel_pkg::link_req_s card_req
);
  initial begin
    card_clk = 1'b0;
    card_req = '0;
  end
  // one rising edge a frame; the clock stands still between frames
  task send(input flash_rel_pkg::link_req_s r);
    #2 card_req = r;
    #60 card_clk = 1'b1;
    #63 card_clk = 1'b0;
    // released lines show garbage, not the last request
    card_req = ~r;
  endtask
endmodule

/* sim/tb_flash_write_reliability_trim.sv */
`timescale 1ns/1ns
`include "flash_rel_consts.svh"
module tb_flash_write_reliability_trim;
  localparam int MS = 5;
  localparam int LIM = 300 * 2 * 17 * MS;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, purge_done = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q, prdata_ro, q2;
  logic atomic_ro;
  logic pready, pslverr, e, card_clk, wr_start, wr_reliable, wr_protected, wr_atomic;
  logic purge_start, purge_busy, purge_skipped, purge_timeout;
  logic [11:0] wr_unit_len;
  flash_rel_pkg::link_req_s card_req;
  int fail_count = 0, total_checks = 0, cyc = 0, n_wr = 0, n_ps = 0, n_sk = 0, n_to = 0;
  int t_ps, t_to;
  always #5 pclk = ~pclk;
  card_host_model u_card_host_model (.card_clk(card_clk), .card_req(card_req));
  flash_write_reliability_trim #(.MS_CYCLES(MS)) u_flash_write_reliability_trim (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .card_clk(card_clk), .card_req(card_req), .purge_done(purge_done),
    .wr_start(wr_start), .wr_reliable(wr_reliable), .wr_protected(wr_protected),
    .wr_atomic(wr_atomic), .wr_unit_len(wr_unit_len), .purge_start(purge_start),
    .purge_busy(purge_busy), .purge_skipped(purge_skipped), .purge_timeout(purge_timeout));
  // second copy without host control or enhanced writes, on the same bus and link
  flash_write_reliability_trim #(.SUPPORT(8'h00), .MS_CYCLES(MS)) u_flash_write_reliability_trim_ro (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata_ro), .pready(), .pslverr(),
    .card_clk(card_clk), .card_req(card_req), .purge_done(purge_done),
    .wr_start(), .wr_reliable(), .wr_protected(), .wr_atomic(atomic_ro), .wr_unit_len(),
    .purge_start(), .purge_busy(), .purge_skipped(), .purge_timeout());
  always @(posedge pclk) begin
    cyc++;
    if (wr_start === 1'b1) n_wr++;
    if (purge_skipped === 1'b1) n_sk++;
    if (purge_start === 1'b1) begin
      n_ps++;
      t_ps = cyc;
    end
    if (purge_timeout === 1'b1 && n_to == 0) begin
      n_to = 1;
      t_to = cyc;
    end
  end
  task end_sim;
    if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask
  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    q2 = prdata_ro;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      $display("[FAIL] pready expected 1 seen %b", pready);
      fail_count++;
      end_sim();
    end
  endtask
  task automatic wait_cnt(ref int cnt, input int goal, input int bound);
    int n;
    for (n = 0; n < bound && cnt < goal; n++) @(posedge pclk);
    if (cnt < goal) begin
      $display("[FAIL] event_count expected %0d seen %0d", goal, cnt);
      fail_count++;
      end_sim();
    end
  endtask
  function flash_rel_pkg::link_req_s rq(logic m, logic p, logic w, logic [2:0] pt);
    return '{m, p, w, 1'b1, pt, 12'h010};
  endfunction
  logic [7:0] idx_tab [6] = '{`IDX_SUPPORT, `IDX_CONFIG, `IDX_SECTOR_COUNT,
    `IDX_PURGE_MULT, `IDX_ERASED, `IDX_ERASE_MULT};
  logic [7:0] rst_tab [6] = '{8'h05, 8'h1f, 8'h01, 8'h11, 8'h00, 8'h01};
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, idx_tab[i], '0);
      chk("reset_value", {24'h00_0000, rst_tab[i]}, q);
    end
    apb(1'b0, 8'h00, '0);
    chk("unmapped_err", 32'h0000_0001, {31'h0, e});
    chk("unmapped_data", 32'h0000_0000, q);
    apb(1'b1, `IDX_CONFIG, 32'h0000_00e2);
    apb(1'b0, `IDX_CONFIG, '0);
    chk("config", 32'h0000_0002, q);
    chk("config_ro", 32'h0000_001f, q2);
    for (int p = 0; p < 6; p++) begin
      u_card_host_model.send(rq(1'b0, 1'b0, 1'b1, 3'(p)));
      wait_cnt(n_wr, p + 1, 40);
      chk("protected", {31'h0, p == 1}, {31'h0, wr_protected});
      chk("rel_attr", 32'h0000_0003, {30'h0, wr_reliable, wr_atomic});
      chk("unit_len", 32'h0000_0200, {20'h0, wr_unit_len});
    end
    chk("legacy_atomic", 32'h0000_0000, {31'h0, atomic_ro});
    u_card_host_model.send(flash_rel_pkg::link_req_s'{1'b0, 1'b0, 1'b1, 1'b0, 3'h2, 12'h010});
    wait_cnt(n_wr, 7, 40);
    chk("plain_len", 32'h0000_0010, {20'h0, wr_unit_len});
    chk("plain_attr", 32'h0000_0000, {30'h0, wr_reliable, wr_atomic});
    u_card_host_model.send(rq(1'b0, 1'b1, 1'b0, 3'h0));
    wait_cnt(n_sk, 1, 40);
    chk("empty_purge", 32'h0000_0000, n_ps);
    u_card_host_model.send(rq(1'b1, 1'b0, 1'b0, 3'h0));
    apb(1'b0, `IDX_ERASED, '0);
    chk("marked", 32'h0000_0001, q);
    u_card_host_model.send(rq(1'b0, 1'b1, 1'b0, 3'h0));
    wait_cnt(n_ps, 1, 40);
    apb(1'b0, `IDX_ERASED, '0);
    chk("marked_busy", 32'h0000_0003, {30'h0, purge_busy, q[0]});
    purge_done <= 1'b1;
    @(posedge pclk);
    purge_done <= 1'b0;
    apb(1'b0, `IDX_ERASED, '0);
    chk("purged", 32'h0000_0000, {30'h0, purge_busy, q[0]});
    apb(1'b1, `IDX_ERASE_MULT, 32'h0000_0002);
    u_card_host_model.send(rq(1'b1, 1'b0, 1'b0, 3'h0));
    u_card_host_model.send(rq(1'b0, 1'b1, 1'b0, 3'h0));
    wait_cnt(n_to, 1, LIM + 200);
    chk("purge_limit", 32'h0000_0001,
      {31'h0, t_to - t_ps >= LIM - 2 && t_to - t_ps <= LIM + 4});
    apb(1'b0, `IDX_ERASED, '0);
    chk("marks_kept", 32'h0000_0001, {30'h0, purge_busy, q[0]});
    apb(1'b0, `IDX_STATUS, '0);
    chk("status", 32'h0000_000a, q);
    end_sim();
  end
endmodule
